//--- design/ccp_top.sv
// Purpose: two-wire control port with registers and status
// Assumes: clk_link is free running and much faster than scl
// Notes: protocol logic oversamples the pins on clk_link
`timescale 1ns/10ps
`default_nettype none
module ccp_top
  import ccp_pkg::*;
#(
  parameter int RAMP_LEN = RAMP_CYCLES,
  parameter logic [7:0] CHIP_ID = CHIP_ID_DEFAULT // arbitrary value
) (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // link clock
  input wire logic clk_link,
  // two-wire pins
  input wire ccp_pins_t pins,
  output logic sda_out,
  output logic sda_oe,
  // strap pin
  input wire logic adc_serial_out_pin,
  // status sources from the converters
  input wire logic [STATUS_W-1:0] status_src,
  // system side results
  output logic powerdown_bit,
  output logic mute_adc,
  output logic mute_dac,
  output logic status_flag,
  output logic addr_select_bit
);

  localparam int RW = $clog2(RAMP_LEN + 1);

  typedef struct packed {
    logic rst_q;
    logic addr_bit;
    logic scl_q;
    logic sda_q;
    ccp_state_t st;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic rw;
    logic ack_ok;
    logic sda_oe;
    logic sda_out;
    logic [STATUS_W-1:0] src_q;
    logic [STATUS_W-1:0] status;
    logic flag;
    logic [REG_COUNT-1:0][7:0] regs;
  } ccp_link_t;

  typedef struct packed {
    logic [RW-1:0] ramp;
    logic low_power;
    logic mute_adc;
    logic mute_dac;
  } ccp_sys_t;

  ccp_link_t l;
  ccp_link_t next_l;
  ccp_sys_t s;
  ccp_sys_t next_s;

  logic rst_l;
  ccp_pins_t pins_s;
  logic strap_s;
  logic [STATUS_W-1:0] src_s;
  logic down_s;
  logic flag_s;
  logic addr_s;

  // ==========================================================
  // crossings into the link domain
  ccp_sync #(.W(1), .INIT(1'b1)) u_rst_sync (
    .clk(clk_link),
    .rst(1'b0),
    .d(rst),
    .q(rst_l)
  );

  // pins and sources are asynchronous to clk_link
  // never reset, so the strap level is current at release
  ccp_sync #(.W(3 + STATUS_W), .INIT({3'h7, {STATUS_W{1'b0}}}))
    u_in_sync (
    .clk(clk_link),
    .rst(1'b0),
    .d({pins, adc_serial_out_pin, status_src}),
    .q({pins_s, strap_s, src_s})
  );

  // ==========================================================
  // crossing back into the system domain; all quasi-static levels
  ccp_sync #(.W(3), .INIT(3'h4)) u_out_sync (
    .clk(clk_sys),
    .rst(rst),
    .d({l.regs[REG_PWR][PWR_DOWN_BIT], l.flag, l.addr_bit}),
    .q({down_s, flag_s, addr_s})
  );

  // ==========================================================
  // link domain: protocol engine, register file, status
  logic rise;
  logic fall;
  logic start_c;
  logic stop_c;
  logic [7:0] rd_byte;
  logic [STATUS_W-1:0] clr;
  logic load;
  logic [1:0] mode;
  logic ev;

  // read data mux; status and id are not held in storage
  always_comb begin
    rd_byte = 8'h00;
    if (l.ptr == REG_STATUS) begin
      rd_byte = l.status;
    end else if (l.ptr == REG_ID) begin
      rd_byte = CHIP_ID;
    end else if (l.ptr < 8'(REG_COUNT)) begin
      rd_byte = l.regs[l.ptr[4:0]];
    end
  end

  always_comb begin
    next_l = l;
    clr = '0;
    load = 1'b0;
    mode = 2'h0;
    ev = 1'b0;
    // edges of the synchronised pins
    rise = pins_s.scl & ~l.scl_q;
    fall = ~pins_s.scl & l.scl_q;
    // data moving under a high clock marks start or stop
    start_c = pins_s.scl & l.scl_q & l.sda_q & ~pins_s.sda;
    stop_c = pins_s.scl & l.scl_q & ~l.sda_q & pins_s.sda;
    next_l.scl_q = pins_s.scl;
    next_l.sda_q = pins_s.sda;
    next_l.sda_out = 1'b0;
    // strap taken on the first link edge after release
    next_l.rst_q = rst_l;
    if (l.rst_q && !rst_l) begin
      next_l.addr_bit = strap_s;
    end

    if (start_c) begin
      next_l.st = CCP_ADDR;
      next_l.cnt = 4'h0;
      next_l.sda_oe = 1'b0;
    end else if (stop_c) begin
      next_l.st = CCP_IDLE;
      next_l.sda_oe = 1'b0;
    end else begin
      case (l.st)
        CCP_ADDR, CCP_PTR, CCP_WR: begin
          if (rise) begin
            next_l.shreg = {l.shreg[6:0], pins_s.sda};
            next_l.cnt = l.cnt + 4'h1;
          end else if (fall && l.cnt == 4'h8) begin
            next_l.cnt = 4'h0;
            next_l.sda_oe = 1'b1; // ack each received byte
            if (l.st == CCP_ADDR) begin
              // seven address bits then direction
              if (l.shreg[7:1] == {ADDR_HI, l.addr_bit}) begin
                next_l.rw = l.shreg[0];
                next_l.st = CCP_ADDR_ACK;
              end else begin
                next_l.sda_oe = 1'b0; // stay off the bus
                next_l.st = CCP_SKIP;
              end
            end else if (l.st == CCP_PTR) begin
              next_l.ptr = l.shreg;
              next_l.st = CCP_PTR_ACK;
            end else begin
              // id and status are read-only; out of range drops
              if (l.ptr < 8'(REG_COUNT) && l.ptr != REG_STATUS &&
                  l.ptr != REG_ID) begin
                next_l.regs[l.ptr[4:0]] = l.shreg;
              end
              next_l.ptr = l.ptr + 8'h01;
              next_l.st = CCP_WR_ACK;
            end
          end
        end
        CCP_ADDR_ACK: begin
          if (fall) begin
            if (l.rw) begin
              load = 1'b1; // data follows the address ack
            end else begin
              next_l.sda_oe = 1'b0;
              next_l.st = CCP_PTR;
            end
          end
        end
        CCP_PTR_ACK, CCP_WR_ACK: begin
          if (fall) begin
            next_l.sda_oe = 1'b0;
            next_l.st = CCP_WR;
          end
        end
        CCP_RD: begin
          if (rise) begin
            next_l.cnt = l.cnt + 4'h1;
          end else if (fall) begin
            if (l.cnt == 4'h8) begin
              next_l.cnt = 4'h0;
              next_l.sda_oe = 1'b0; // controller owns the ack slot
              next_l.st = CCP_RD_ACK;
            end else begin
              next_l.shreg = {l.shreg[6:0], 1'b0};
              next_l.sda_oe = ~l.shreg[6]; // change only on low clock
            end
          end
        end
        CCP_RD_ACK: begin
          if (rise) begin
            next_l.ack_ok = ~pins_s.sda;
          end else if (fall) begin
            if (l.ack_ok) begin
              load = 1'b1;
            end else begin
              next_l.st = CCP_SKIP; // no ack ends the read
            end
          end
        end
        default: begin
          // idle and skip wait for the next start
        end
      endcase
    end

    // fetch a byte to send and step the pointer
    if (load) begin
      next_l.shreg = rd_byte;
      next_l.ptr = l.ptr + 8'h01;
      next_l.sda_oe = ~rd_byte[7];
      next_l.cnt = 4'h0;
      next_l.st = CCP_RD;
      if (l.ptr == REG_STATUS) begin
        clr = '1; // reading status clears the latched edges
      end
    end

    // status capture; a new edge wins over the read clear
    next_l.src_q = src_s;
    for (int i = 0; i < STATUS_W; i++) begin
      mode = {l.regs[REG_MODE_HI][i], l.regs[REG_MODE_LO][i]};
      case (mode)
        2'h0: ev = src_s[i] & ~l.src_q[i];
        2'h1: ev = ~src_s[i] & l.src_q[i];
        default: ev = src_s[i];
      endcase
      if (mode[1]) begin
        next_l.status[i] = ev & STATUS_IMPL[i]; // level follows
      end else begin
        next_l.status[i] = ((l.status[i] & ~clr[i]) | ev) &
                           STATUS_IMPL[i];
      end
    end
    // masked sources do not reach the indication
    next_l.flag = |(l.status & ~l.regs[REG_MASK]);

    // reset holds every link state at its reset value
    if (rst_l) begin
      next_l = '0;
      next_l.rst_q = 1'b1;
      next_l.scl_q = 1'b1;
      next_l.sda_q = 1'b1;
      next_l.st = CCP_IDLE;
      next_l.regs[REG_PWR] = PWR_RESET;
    end
  end

  always_ff @(posedge clk_link) begin
    l <= next_l;
  end

  // ==========================================================
  // system domain: power state and reference ramp muting
  always_comb begin
    next_s = s;
    next_s.low_power = down_s; // runs once bit is cleared
    if (down_s) begin
      next_s.ramp = '0;
    end else if (s.ramp != RW'(RAMP_LEN)) begin
      next_s.ramp = s.ramp + RW'(1);
    end
    // muted while powered down or reference ramping
    next_s.mute_adc = down_s | (s.ramp != RW'(RAMP_LEN));
    next_s.mute_dac = down_s | (s.ramp != RW'(RAMP_LEN));
    if (rst) begin
      next_s.ramp = '0;
      next_s.low_power = 1'b1;
      next_s.mute_adc = 1'b1;
      next_s.mute_dac = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    s <= next_s;
  end

  // ==========================================================
  // outputs, all from flops
  assign sda_out = l.sda_out;
  assign sda_oe = l.sda_oe;
  assign powerdown_bit = s.low_power;
  assign mute_adc = s.mute_adc;
  assign mute_dac = s.mute_dac;
  assign status_flag = flag_s;
  assign addr_select_bit = addr_s;

endmodule
`default_nettype wire

//--- common/ccp_pkg.sv
// Purpose: constants and types of the codec two-wire control port
// Assumes: register pointer of 8 bits, register file of 32 bytes
// Notes: shared by the control port top, its assertions and the bench
//
// Operation
// - answer only address 100111 plus strap bit
// - strap bit sampled from serial pin at release
// - first byte: seven address bits, direction bit
// - write: byte after address loads register pointer
// - read: shift selected register right after ack
// - pointer increments after every data byte
// - device acks received bytes; controller acks sent
// - data changes only while clock low, except start/stop
// - port runs unrelated to audio clocks
// - each status source has its own mask
// - status source: rising, falling or level
// - reset holds everything at reset value, muted
// - after reset, clear powerdown bit to run
// - mute adc and dac while reference ramps
// - powerdown bit is bit 0, resets high
`default_nettype none
package ccp_pkg;

  // ==========================================================
  // bus address and register map
  localparam logic [5:0] ADDR_HI = 6'h27;
  localparam int REG_COUNT = 32;
  localparam logic [7:0] REG_ID = 8'h01;
  localparam logic [7:0] REG_PWR = 8'h02;
  localparam logic [7:0] REG_STATUS = 8'h0D;
  localparam logic [7:0] REG_MASK = 8'h0E;
  localparam logic [7:0] REG_MODE_HI = 8'h0F;
  localparam logic [7:0] REG_MODE_LO = 8'h10;

  // ==========================================================
  // field positions and reset values
  localparam int PWR_DOWN_BIT = 0;
  localparam logic [7:0] PWR_RESET = 8'h01;
  localparam logic [7:0] STATUS_IMPL = 8'h1B;
  localparam logic [7:0] CHIP_ID_DEFAULT = 8'h5A; // arbitrary value
  localparam int STATUS_W = 8;

  // ==========================================================
  // timing
  localparam int CLK_HZ = 20000000;
  localparam int RAMP_MS = 200;
  localparam int RAMP_CYCLES = RAMP_MS * (CLK_HZ / 1000);

  // ==========================================================
  // types
  typedef enum logic [3:0] {
    CCP_IDLE, CCP_ADDR, CCP_ADDR_ACK, CCP_PTR, CCP_PTR_ACK,
    CCP_WR, CCP_WR_ACK, CCP_RD, CCP_RD_ACK, CCP_SKIP
  } ccp_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } ccp_pins_t;

endpackage
`default_nettype wire

//--- design/ccp_sync.sv
// Purpose: two flip-flop level synchroniser
// Assumes: inputs are levels that stay put for several clocks
// Notes: first stage is read only by the second stage
`timescale 1ns/10ps
`default_nettype none
module ccp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset of the receiving domain
  input wire logic clk,
  input wire logic rst,
  // level in and synchronised level out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } ccp_sync_state_t;

  ccp_sync_state_t s;
  ccp_sync_state_t next_s;

  // ==========================================================
  // stage shift
  always_comb begin
    next_s.meta = d;
    next_s.stable = s.meta;
    if (rst) begin
      next_s.meta = INIT;
      next_s.stable = INIT;
    end
  end

  always_ff @(posedge clk) begin
    s <= next_s;
  end

  assign q = s.stable;

endmodule
`default_nettype wire

//--- test/ccp_top_sva.sv
// Purpose: assertions on the control port outputs
// Assumes: rst is synchronous to clk_sys
// Notes: bound to every ccp_top instance
`timescale 1ns/10ps
`default_nettype none
module ccp_top_sva
  import ccp_pkg::*;
#(
  parameter int RAMP_LEN = 20
) (
  // clocks and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_link,
  // pins
  input wire ccp_pins_t pins,
  input wire logic sda_oe,
  input wire logic adc_serial_out_pin,
  // system side
  input wire logic powerdown_bit,
  input wire logic mute_adc,
  input wire logic mute_dac,
  input wire logic status_flag,
  input wire logic addr_select_bit
);
  // ==========================================================
  // helper counters
  int unsigned run_cnt;
  int unsigned rel_cnt;
  // cycles since power-down cleared and since reset release
  always_ff @(posedge clk_sys) begin
    if (rst || powerdown_bit) begin
      run_cnt <= 0;
    end else if (run_cnt < RAMP_LEN + 8) begin
      run_cnt <= run_cnt + 1;
    end
    if (rst) begin
      rel_cnt <= 0;
    end else if (rel_cnt < 16) begin
      rel_cnt <= rel_cnt + 1;
    end
  end

  // ==========================================================
  // assertions
  rst_state_a: assert property (@(posedge clk_sys)
    rst [*6] |-> powerdown_bit && mute_adc && mute_dac && !status_flag)
    else $error("reset state not held");
  rst_link_a: assert property (@(posedge clk_link)
    rst [*6] |-> !sda_oe)
    else $error("sda driven in reset");
  mute_ramp_a: assert property (@(posedge clk_sys) disable iff (rst)
    !powerdown_bit && run_cnt + 3 < RAMP_LEN |-> mute_adc && mute_dac)
    else $error("mute dropped during ramp");
  mute_end_a: assert property (@(posedge clk_sys) disable iff (rst)
    run_cnt == RAMP_LEN + 4 |-> !mute_adc && !mute_dac)
    else $error("mute not released");
  mute_pair_a: assert property (@(posedge clk_sys) disable iff (rst)
    mute_adc == mute_dac)
    else $error("mutes differ");
  strap_fix_a: assert property (@(posedge clk_sys) disable iff (rst)
    $changed(addr_select_bit) |-> rel_cnt < 12)
    else $error("strap bit moved late");
  strap_val_a: assert property (@(posedge clk_sys) disable iff (rst)
    rel_cnt == 12 |-> addr_select_bit == adc_serial_out_pin)
    else $error("strap bit wrong");
  oe_scl_low_a: assert property (@(posedge clk_link) disable iff (rst)
    $changed(sda_oe) |-> !pins.scl)
    else $error("sda moved with scl high");
  oe_hold_a: assert property (@(posedge clk_link) disable iff (rst)
    $rose(sda_oe) |-> sda_oe [*8])
    else $error("sda drive too short");
endmodule

bind ccp_top ccp_top_sva #(.RAMP_LEN(RAMP_LEN)) chk (
  .clk_sys(clk_sys), .rst(rst), .clk_link(clk_link), .pins(pins),
  .sda_oe(sda_oe), .adc_serial_out_pin(adc_serial_out_pin),
  .powerdown_bit(powerdown_bit), .mute_adc(mute_adc),
  .mute_dac(mute_dac), .status_flag(status_flag),
  .addr_select_bit(addr_select_bit)
);
`default_nettype wire

//--- test/ccp_ctl_model.sv
// Purpose: two-wire bus controller model
// Assumes: sda is open drain with a pull-up
// Notes: each scl phase lasts four clk cycles
`timescale 1ns/10ps
`default_nettype none
module ccp_ctl_model (
  // timing clock and wired sda level
  input wire logic clk,
  input wire logic sda_in,
  // lines driven, 1 = released
  output logic scl,
  output logic sda_drv
);
  // lines rest high between frames
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  // sda falls with scl high
  task automatic start();
    sda_drv <= 1'b1;
    hold(2);
    scl <= 1'b1;
    hold(4);
    sda_drv <= 1'b0;
    hold(4);
    scl <= 1'b0;
    hold(2);
  endtask
  // sda rises with scl high
  task automatic stop();
    sda_drv <= 1'b0;
    hold(2);
    scl <= 1'b1;
    hold(4);
    sda_drv <= 1'b1;
    hold(4);
  endtask
  // data moves only while scl low; 0 here acks a byte
  task automatic bit_io(input logic b, output logic r);
    sda_drv <= b;
    hold(2);
    scl <= 1'b1;
    hold(4);
    r = sda_in;
    scl <= 1'b0;
    hold(2);
  endtask
  // msb first
  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
  endtask
endmodule
`default_nettype wire

//--- test/testbench.sv
// Purpose: self-checking bench of the control port
// Assumes: strap pulled up, then down; ramp shortened to 20 cycles
// Notes: bus traffic comes from the controller model
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import ccp_pkg::*;
  localparam int RAMP = 20;
  localparam logic [7:0] ID = 8'hA5; // arbitrary value
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic rst = 1'b1;
  logic [7:0] src = 8'h00;
  logic strap = 1'b1;
  logic sda_oe, pd, mute_a, mute_d, flag, asel, scl, sda_drv, sda;
  logic sda_o;
  logic [6:0] dev = {ADDR_HI, 1'b1};
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  // ==========================================================
  // clocks, wired sda, instances
  always #25 clk_sys = ~clk_sys;
  initial begin
    #7;
    forever #16 clk_link = ~clk_link;
  end
  // open drain: the device shows its data level only while enabled
  assign sda = sda_drv & (~sda_oe | sda_o);
  ccp_top #(.RAMP_LEN(RAMP), .CHIP_ID(ID)) dut (
    .clk_sys(clk_sys), .rst(rst), .clk_link(clk_link),
    .pins({scl, sda}), .sda_out(sda_o), .sda_oe(sda_oe),
    .adc_serial_out_pin(strap), .status_src(src),
    .powerdown_bit(pd), .mute_adc(mute_a), .mute_dac(mute_d),
    .status_flag(flag), .addr_select_bit(asel));
  ccp_ctl_model ctl (.clk(clk_sys), .sda_in(sda), .scl(scl),
    .sda_drv(sda_drv));
  // ==========================================================
  // helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want) begin
      n_errors++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // flag settles within a bounded wait
  task automatic flag_is(input logic want);
    for (int i = 0; i < 40 && flag !== want; i++)
      tick(1);
    check(flag, want);
  endtask
  task automatic open_dev(input logic [6:0] a, input logic rw,
                          input logic acked);
    logic [7:0] rx;
    logic ack;
    ctl.start();
    ctl.byte_io({a, rw}, rx);
    ctl.bit_io(1'b1, ack);
    check(ack, !acked);
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [15:0] d,
                    input int n);
    logic [7:0] rx;
    logic ack;
    open_dev(dev, 1'b0, 1'b1);
    ctl.byte_io(ptr, rx);
    ctl.bit_io(1'b1, ack);
    check(ack, 1'b0);
    for (int i = n; i > 0; i--) begin
      ctl.byte_io(d[8*i-1 -: 8], rx);
      ctl.bit_io(1'b1, ack);
      check(ack, 1'b0);
    end
    ctl.stop();
  endtask
  // aborted write sets the pointer, then two bytes are read
  task automatic rd(input logic [7:0] ptr, input logic [15:0] want);
    logic [7:0] rx;
    logic ack;
    wr(ptr, 16'h0000, 0);
    open_dev(dev, 1'b1, 1'b1);
    ctl.byte_io(8'hFF, rx);
    check(rx, want[15:8]);
    ctl.bit_io(1'b0, ack);
    ctl.byte_io(8'hFF, rx);
    check(rx, want[7:0]);
    ctl.bit_io(1'b1, ack);
    ctl.stop();
  endtask
  // ceiling on the whole run
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      end_of_test();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] rx;
    logic ack;
    logic [6:0] bad [3];
    bad = '{7'h4E, 7'h4D, 7'h0F};
    tick(8);
    rst <= 1'b0; // released on a clock edge of the one source
    tick(20);
    check(asel, 1'b1);
    check({pd, mute_a, mute_d, flag}, 4'hE);
    foreach (bad[i]) begin
      open_dev(bad[i], 1'b0, 1'b0);
      ctl.byte_io(8'h00, rx);
      ctl.bit_io(1'b1, ack);
      check(ack, 1'b1);
      ctl.stop();
    end
    rd(REG_ID, {ID, PWR_RESET});
    $display("test address done");
    src <= 8'h01;
    flag_is(1'b1);
    src <= 8'h00;
    rd(REG_STATUS, 16'h0100);
    flag_is(1'b0);
    wr(REG_MASK, 16'h0001, 1);
    src <= 8'h01;
    tick(40);
    check(flag, 1'b0);
    wr(REG_MASK, 16'h0000, 1);
    flag_is(1'b1);
    src <= 8'h00;
    rd(REG_STATUS, 16'h0100);
    wr(REG_MODE_HI, 16'h0800, 2);
    src <= 8'h08;
    flag_is(1'b1);
    src <= 8'h00;
    flag_is(1'b0);
    wr(REG_MODE_HI, 16'h0002, 2);
    src <= 8'h02;
    tick(40);
    check(flag, 1'b0);
    src <= 8'h00;
    flag_is(1'b1);
    rd(REG_STATUS, 16'h0200);
    $display("test status done");
    wr(REG_PWR, 16'h0000, 1);
    for (int i = 0; i < 40 && pd !== 1'b0; i++)
      tick(1);
    check({pd, mute_a, mute_d}, 3'h3);
    tick(RAMP + 6);
    check({mute_a, mute_d}, 2'h0);
    rst <= 1'b1;
    strap <= 1'b0; // pulled down across this reset
    tick(8);
    rst <= 1'b0;
    tick(20);
    check({pd, mute_a, mute_d}, 3'h7);
    check(asel, 1'b0);
    // the old address must now be refused
    open_dev(dev, 1'b0, 1'b0);
    ctl.stop();
    dev = {ADDR_HI, 1'b0};
    rd(REG_PWR, {PWR_RESET, 8'h00});
    $display("test power done");
    end_of_test();
  end
endmodule
`default_nettype wire
